// file: core/mce_capture.sv
// Machine-check error detection, capture and reporting.
// Assumes all inputs synchronous to core_clk; sysCycle marks core cycles that align with a system clock edge.
//
// Summary of operation
// - Data-stream tag parity error: mcheck, flag set
// - Tag hit ignores parity; victim from status
// - Capture address bits 39..4 of octaword
// - Bus parity error: mcheck, flags, nack unless nop
// - Ratio 3: command after bad nop unacknowledged
// - Outgoing board-cache data not ECC checked
// - Correctable fill corrected; data cache invalidated
// - Correctable interrupt at level 31, enable-masked
// - Correctable error sets summary and status flags
// - Syndrome loaded; tag probe not loaded
// - Fill error only traps to machine check
// - System mcheck masked at 31, firmware mode
// - Timeout: trap, partial reset, timeout flag
// - Fail without acknowledge acts like timeout
// - L2 status read unlocks L2 address
// - External status read unlocks capture group
// - Cache statuses unlock on 0x1800, 0x03
// - Clearing arithmetic summary unlocks exception mask
// - Writing zero to clear bit acknowledges
// - Refill buffer clean after 32 fetches
`timescale 1ns/1ns
module mce_capture import mce_pkg::*; #(
  parameter int SYN_W = 16,
  parameter int TAG_W = 32,
  parameter int DATA_W = 128,
  parameter int EXC_W = 64
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [3:0] clkRatio,
  input wire logic [4:0] ipl,
  input wire logic privMode,
  input wire logic crdEnable,
  input wire logic bcProbe,
  input wire logic bcProbeIstream,
  input wire logic bcTagMatch,
  input wire logic bcTagParOk,
  input wire logic bcCtlParOk,
  input wire logic [2:0] bcTagStatus,
  input wire logic [TAG_W-1:0] bcProbeResult,
  input wire logic [PA_HI:PA_LO] bcProbeAddr,
  input wire logic sysCycle,
  input wire logic sysCmdValid,
  input wire logic sysCmdNop,
  input wire logic sysCmdParErr,
  input wire logic [PA_HI:PA_LO] sysCmdAddr,
  input wire logic bcReadOut,
  input wire logic [DATA_W-1:0] bcReadOutData,
  input wire logic fillValid,
  input wire logic fillIstream,
  input wire logic fillFromBcache,
  input wire logic fillCorrErr,
  input wire logic [SYN_W-1:0] fillSyndromeIn,
  input wire logic [PA_HI:PA_LO] fillAddr,
  input wire logic [DATA_W-1:0] fillData,
  input wire logic [DATA_W-1:0] fillFlip,
  input wire logic fillErrorIn,
  input wire logic sysMcheckIn,
  input wire logic iuTimeout,
  input wire logic cmdFail,
  input wire logic cmdAckIn,
  input wire logic l2Err,
  input wire logic [PA_HI:PA_LO] l2ErrAddr,
  input wire logic [1:0] icParErr,
  input wire logic [DC_ERR_W-1:0] dcErr,
  input wire logic arithExc,
  input wire logic [EXC_W-1:0] excMaskIn,
  input wire logic ifetchInstr,
  input wire logic rdL2Status,
  input wire logic rdExtStatus,
  input wire logic wrIcStatus,
  input wire logic wrDcStatus,
  input wire logic [15:0] wrData,
  input wire logic clrArithSummary,
  input wire logic wrHwIntClr,
  input wire logic crdClrBit,
  input wire logic mckClrBit,
  output logic bcHit,
  output logic victimWriteback,
  output logic cmdAck,
  output logic cmdNack,
  output logic [DATA_W-1:0] sysDataOut,
  output logic [DATA_W-1:0] corrData,
  output logic l2FillWe,
  output logic icFillWe,
  output logic dcInvalidateAll,
  output logic mcheckTrap,
  output logic partialReset,
  output logic crdInterrupt,
  output logic mckInterrupt,
  output logic isrCrd,
  output logic isrMck,
  output logic [EXT_STATUS_W-1:0] extStatus,
  output logic [PA_HI:PA_LO] extAddress,
  output logic [TAG_W-1:0] tagProbeResult,
  output logic [SYN_W-1:0] fillSyndrome,
  output logic [PA_HI:PA_LO] l2Address,
  output logic l2Locked,
  output logic [15:0] icStatus,
  output logic [DC_STATUS_W-1:0] dcStatus,
  output logic [EXC_W-1:0] excMask,
  output logic refillStale
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic belowMcheck(input logic [4:0] level);
    return level < IPL_MCHECK;
  endfunction : belowMcheck

  // ****************************************
  // Event decode
  // ****************************************
  logic tagErr, ctlErr, extTagEvt, sysParEvt, corrEvt, cfailEvt, resetEvt, istreamErr, extEvt;
  logic [EXT_STATUS_W-1:0] extCapStatus;
  logic [PA_HI:PA_LO] extCapAddr;

  always_comb begin
    tagErr = bcProbe && !bcTagParOk;
    ctlErr = bcProbe && !bcCtlParOk;
    extTagEvt = tagErr || ctlErr;
    sysParEvt = sysCmdValid && sysCmdParErr;
    corrEvt = fillValid && fillCorrErr;
    cfailEvt = sysCycle && cmdFail && !cmdAckIn;
    resetEvt = iuTimeout || cfailEvt;
    istreamErr = (extTagEvt && bcProbeIstream) || (|icParErr);
    extEvt = extTagEvt || sysParEvt || corrEvt;
    extCapStatus = EXT_STATUS_RST;
    extCapStatus[ES_TAG_PAR] = tagErr;
    extCapStatus[ES_TAG_CTL_PAR] = ctlErr;
    extCapStatus[ES_BUS_PAR] = sysParEvt;
    extCapStatus[ES_COR_ECC] = corrEvt;
    // Tag errors are board-cache sourced, so the source flag stays clear for them
    extCapStatus[ES_SYS_SRC] = sysParEvt || (corrEvt && !fillFromBcache);
    extCapStatus[ES_IFILL] = (extTagEvt && bcProbeIstream) || (corrEvt && fillIstream);
    // Highest-severity source names the captured address
    if (extTagEvt) begin
      extCapAddr = bcProbeAddr;
    end else if (sysParEvt) begin
      extCapAddr = sysCmdAddr;
    end else begin
      extCapAddr = fillAddr;
    end
  end

  // ****************************************
  // External capture group
  // ****************************************
  logic [EXT_STATUS_W-2:0] extFlags;
  logic extMulti;

  mce_lock_reg #(.W(EXT_STATUS_W - 1 + PA_W)) u_ext (
    .core_clk(core_clk), .rst(rst), .ce(ce), .capture(extEvt),
    .captureData({extCapStatus[EXT_STATUS_W-2:0], extCapAddr}), .value({extFlags, extAddress}),
    .locked(), .multi(extMulti), .unlock(rdExtStatus));

  assign extStatus = {extMulti, extFlags};

  mce_lock_reg #(.W(TAG_W)) u_tag (
    .core_clk(core_clk), .rst(rst), .ce(ce), .captureData(bcProbeResult), .value(tagProbeResult),
    .locked(), .multi(), .unlock(rdExtStatus),
    .capture(extTagEvt || sysParEvt));

  mce_lock_reg #(.W(SYN_W)) u_syn (
    .core_clk(core_clk), .rst(rst), .ce(ce), .captureData(fillSyndromeIn), .value(fillSyndrome),
    .locked(), .multi(), .unlock(rdExtStatus),
    .capture(corrEvt));

  // ****************************************
  // Other capture registers
  // ****************************************
  mce_lock_reg #(.W(PA_W)) u_l2 (
    .core_clk(core_clk), .rst(rst), .ce(ce), .capture(l2Err), .captureData(l2ErrAddr),
    .value(l2Address), .locked(l2Locked), .multi(), .unlock(rdL2Status));

  logic [DC_ERR_W-1:0] dcFlags;
  logic dcLocked;
  logic dcMulti;

  mce_lock_reg #(.W(DC_ERR_W)) u_dc (
    .core_clk(core_clk), .rst(rst), .ce(ce), .capture(|dcErr), .captureData(dcErr),
    .value(dcFlags), .locked(dcLocked), .multi(dcMulti),
    .unlock(wrDcStatus && wrData[7:0] == DC_UNLOCK_VAL));

  assign dcStatus = {dcMulti, dcLocked, dcFlags};

  mce_lock_reg #(.W(EXC_W)) u_exc (
    .core_clk(core_clk), .rst(rst), .ce(ce), .capture(arithExc), .captureData(excMaskIn),
    .value(excMask), .locked(), .multi(), .unlock(clrArithSummary));

  mce_refill_track #(.DEPTH(REFILL_DEPTH)) u_refill (
    .core_clk(core_clk), .rst(rst), .ce(ce), .istreamErr(istreamErr), .fetch(ifetchInstr),
    .stale(refillStale));

  // ****************************************
  // Instruction-cache status and summary flags
  // ****************************************
  logic [15:0] next_icStatus;
  logic next_isrCrd;
  logic next_isrMck;

  always_comb begin
    next_icStatus = icStatus;
    next_isrCrd = isrCrd;
    next_isrMck = isrMck;
    if (wrIcStatus && wrData == IC_UNLOCK_VAL) begin
      next_icStatus = IC_STATUS_RST;
    end
    // Sets come after clears so a same-cycle event survives
    if (icParErr[0]) begin
      next_icStatus[IC_DPE] = 1'b1;
    end
    if (icParErr[1]) begin
      next_icStatus[IC_TPE] = 1'b1;
    end
    if (resetEvt) begin
      next_icStatus[IC_TMR] = 1'b1;
    end
    if (wrHwIntClr && !crdClrBit) begin
      next_isrCrd = 1'b0;
    end
    if (wrHwIntClr && !mckClrBit) begin
      next_isrMck = 1'b0;
    end
    if (corrEvt) begin
      next_isrCrd = 1'b1;
    end
    if (sysMcheckIn && belowMcheck(ipl) && !privMode) begin
      next_isrMck = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      icStatus <= IC_STATUS_RST;
      isrCrd <= 1'b0;
      isrMck <= 1'b0;
    end else if (ce) begin
      icStatus <= next_icStatus;
      isrCrd <= next_isrCrd;
      isrMck <= next_isrMck;
    end
  end

  assign crdInterrupt = isrCrd && crdEnable && belowMcheck(ipl);
  assign mckInterrupt = isrMck;

  // ****************************************
  // System command response
  // ****************************************
  mce_cmd_t cmdState;
  mce_cmd_t next_cmdState;
  logic next_cmdAck;
  logic next_cmdNack;
  logic realCmd;

  always_comb begin
    realCmd = sysCmdValid && !sysCmdNop;
    next_cmdAck = 1'b0;
    next_cmdNack = 1'b0;
    next_cmdState = CMD_IDLE;
    case (cmdState)
      CMD_IDLE: begin
        if (realCmd && sysCmdParErr) begin
          next_cmdNack = 1'b1;
        end else if (realCmd) begin
          next_cmdAck = 1'b1;
        end
      end
      CMD_SKIP: begin
        // A good command right behind a bad nop is dropped without any response; a bad-parity one is still nacked
        if (realCmd && sysCmdParErr) begin
          next_cmdNack = 1'b1;
        end
      end
      default: begin
        next_cmdState = CMD_IDLE;
      end
    endcase
    if (sysCmdValid && sysCmdNop && sysCmdParErr && clkRatio == RATIO_THREE) begin
      next_cmdState = CMD_SKIP;
    end
    if (resetEvt) begin
      next_cmdState = CMD_IDLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cmdState <= CMD_IDLE;
      cmdAck <= 1'b0;
      cmdNack <= 1'b0;
    end else if (ce) begin
      cmdState <= next_cmdState;
      cmdAck <= next_cmdAck;
      cmdNack <= next_cmdNack;
    end
  end

  // ****************************************
  // Data paths, traps and partial reset
  // ****************************************
  logic next_bcHit;
  logic next_victimWriteback;
  logic [DATA_W-1:0] next_sysDataOut;
  logic [DATA_W-1:0] next_corrData;
  logic next_l2FillWe;
  logic next_icFillWe;
  logic next_dcInvalidateAll;
  logic next_mcheckTrap;
  logic next_partialReset;

  always_comb begin
    // Hit and victim decisions ignore both parity checks; software sorts out false hits
    next_bcHit = bcProbe && bcTagMatch && bcTagStatus[TS_VALID];
    next_victimWriteback = bcProbe && !bcTagMatch && bcTagStatus[TS_VALID] && bcTagStatus[TS_DIRTY];
    // Passed straight through; the receiving processor checks the code
    next_sysDataOut = bcReadOut ? bcReadOutData : sysDataOut;
    next_corrData = corrData;
    if (fillValid) begin
      next_corrData = fillCorrErr ? (fillData ^ fillFlip) : fillData;
    end
    // No write-back of the corrected word: the board cache keeps the bad copy
    next_l2FillWe = fillValid;
    next_icFillWe = fillValid && fillIstream;
    next_dcInvalidateAll = corrEvt;
    next_mcheckTrap = extTagEvt || sysParEvt || l2Err || (|icParErr) || (|dcErr)
      || fillErrorIn || resetEvt;
    next_partialReset = resetEvt;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bcHit <= 1'b0;
      victimWriteback <= 1'b0;
      sysDataOut <= '0;
      corrData <= '0;
      l2FillWe <= 1'b0;
      icFillWe <= 1'b0;
      dcInvalidateAll <= 1'b0;
      mcheckTrap <= 1'b0;
      partialReset <= 1'b0;
    end else if (ce) begin
      bcHit <= next_bcHit;
      victimWriteback <= next_victimWriteback;
      sysDataOut <= next_sysDataOut;
      corrData <= next_corrData;
      l2FillWe <= next_l2FillWe;
      icFillWe <= next_icFillWe;
      dcInvalidateAll <= next_dcInvalidateAll;
      mcheckTrap <= next_mcheckTrap;
      partialReset <= next_partialReset;
    end
  end

endmodule : mce_capture

// file: core/mce_pkg.sv
// Constants, field layouts and types for the machine-check error capture block.
// Assumes a single core clock; system-bus inputs arrive already synchronous to it.
package mce_pkg;

  // ****************************************
  // Widths and thresholds
  // ****************************************
  localparam int PA_HI = 39;
  localparam int PA_LO = 4;
  localparam int PA_W = PA_HI - PA_LO + 1;
  localparam logic [4:0] IPL_MCHECK = 5'h1f;
  localparam logic [3:0] RATIO_THREE = 4'h3;
  localparam int REFILL_DEPTH = 32;

  // ****************************************
  // Unlock values written by software
  // ****************************************
  localparam logic [15:0] IC_UNLOCK_VAL = 16'h1800;
  localparam logic [7:0] DC_UNLOCK_VAL = 8'h03;

  // ****************************************
  // External error status fields
  // ****************************************
  localparam int ES_TAG_PAR = 0;
  localparam int ES_TAG_CTL_PAR = 1;
  localparam int ES_SYS_SRC = 2;
  localparam int ES_IFILL = 3;
  localparam int ES_BUS_PAR = 4;
  localparam int ES_COR_ECC = 5;
  localparam int ES_MULTI = 6;
  localparam int EXT_STATUS_W = 7;
  localparam logic [EXT_STATUS_W-1:0] EXT_STATUS_RST = 7'h00;

  // ****************************************
  // Instruction-cache error status fields
  // ****************************************
  localparam int IC_DPE = 11;
  localparam int IC_TPE = 12;
  localparam int IC_TMR = 13;
  localparam logic [15:0] IC_STATUS_RST = 16'h0000;

  // ****************************************
  // Data-cache error status fields
  // ****************************************
  localparam int DC_ERR_W = 4;
  localparam int DC_LOCK = 4;
  localparam int DC_SEO = 5;
  localparam int DC_STATUS_W = 6;

  // ****************************************
  // Board-cache tag status fields
  // ****************************************
  localparam int TS_VALID = 0;
  localparam int TS_DIRTY = 1;
  localparam int TS_SHARED = 2;

  // ****************************************
  // System command response state
  // ****************************************
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_SKIP = 2'b10
  } mce_cmd_t;

endpackage : mce_pkg

// file: core/mce_lock_reg.sv
// Lockable error capture register with multiple-error flag.
// Assumes capture and unlock are one-cycle strobes on core_clk.
`timescale 1ns/1ns
module mce_lock_reg import mce_pkg::*; #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic capture,
  input wire logic [W-1:0] captureData,
  input wire logic unlock,
  output logic [W-1:0] value,
  output logic locked,
  output logic multi
);

  logic [W-1:0] next_value;
  logic next_locked;
  logic next_multi;

  always_comb begin
    next_value = value;
    next_locked = locked;
    next_multi = multi;
    if (unlock) begin
      next_locked = 1'b0;
      next_multi = 1'b0;
    end
    // A capture in the unlock cycle still lands: the new error is not lost
    if (capture && (!locked || unlock)) begin
      next_value = captureData;
      next_locked = 1'b1;
    end else if (capture) begin
      next_multi = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      value <= '0;
      locked <= 1'b0;
      multi <= 1'b0;
    end else if (ce) begin
      value <= next_value;
      locked <= next_locked;
      multi <= next_multi;
    end
  end

endmodule : mce_lock_reg

// file: core/mce_refill_track.sv
// Tracks refill-buffer staleness after an instruction-stream error.
// Assumes one fetch strobe per instruction passed through the refill buffer.
`timescale 1ns/1ns
module mce_refill_track import mce_pkg::*; #(
  parameter int DEPTH = REFILL_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic istreamErr,
  input wire logic fetch,
  output logic stale
);

  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] LAST = CW'(DEPTH - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic next_stale;

  always_comb begin
    next_count = count;
    next_stale = stale;
    // A new error restarts the count; old entries may be poisoned again
    if (istreamErr) begin
      next_stale = 1'b1;
      next_count = '0;
    end else if (stale && fetch) begin
      if (count == LAST) begin
        next_stale = 1'b0;
        next_count = '0;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      count <= '0;
      stale <= 1'b0;
    end else if (ce) begin
      count <= next_count;
      stale <= next_stale;
    end
  end

endmodule : mce_refill_track

// file: tb/mce_capture_asserts.sv
// Port-level checks for the capture block, bound into every instance.
// Assumes a synchronous active-high reset and clock enable held high.
`timescale 1ns/1ns
module mce_capture_asserts import mce_pkg::*; #(
  parameter int DATA_W = 128
) (
  input wire logic core_clk, rst, privMode, crdEnable, bcProbe, bcProbeIstream, bcTagParOk,
  input wire logic sysCmdValid, sysCmdNop, sysCmdParErr, fillValid, fillCorrErr, fillErrorIn,
  input wire logic sysMcheckIn, iuTimeout, cmdFail, cmdAckIn, sysCycle, mcheckTrap, partialReset,
  input wire logic cmdAck, cmdNack, isrCrd, isrMck, crdInterrupt, l2FillWe, dcInvalidateAll,
  input wire logic [4:0] ipl,
  input wire logic [DATA_W-1:0] fillData, fillFlip, corrData,
  input wire logic [15:0] icStatus
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_tagPar; bcProbe && !bcTagParOk && !bcProbeIstream |=> mcheckTrap; endproperty
  a_tagPar: assert property (p_tagPar) else $error("tag parity without trap");
  property p_parNack; sysCmdValid && !sysCmdNop && sysCmdParErr |=> cmdNack && !cmdAck && mcheckTrap; endproperty
  a_parNack: assert property (p_parNack) else $error("bad parity command not refused");
  property p_corrFill;
    fillValid && fillCorrErr |=> l2FillWe && dcInvalidateAll && isrCrd && corrData == ($past(fillData) ^ $past(fillFlip));
  endproperty
  a_corrFill: assert property (p_corrFill) else $error("correctable fill mishandled");
  property p_crdIrq; crdInterrupt == (isrCrd && crdEnable && ipl < IPL_MCHECK); endproperty
  a_crdIrq: assert property (p_crdIrq) else $error("correctable interrupt wrong");
  property p_fillErr; fillErrorIn && !iuTimeout && !cmdFail |=> mcheckTrap && !partialReset; endproperty
  a_fillErr: assert property (p_fillErr) else $error("fill error response wrong");
  property p_mckMask; sysMcheckIn && !isrMck && (privMode || ipl == IPL_MCHECK) |=> !isrMck; endproperty
  a_mckMask: assert property (p_mckMask) else $error("masked system check taken");
  property p_timeout;
    iuTimeout ##1 !iuTimeout && !cmdFail |-> partialReset && icStatus[IC_TMR] ##1 !partialReset;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout response wrong");
  property p_cmdFail; sysCycle && cmdFail && !cmdAckIn |=> partialReset && mcheckTrap && icStatus[IC_TMR]; endproperty
  a_cmdFail: assert property (p_cmdFail) else $error("failed command not reset");
  c_tagPar: cover property (bcProbe && !bcTagParOk);
  c_crdClr: cover property (isrCrd ##1 !isrCrd);
  c_cmdFail: cover property (sysCycle && cmdFail && !cmdAckIn);
endmodule : mce_capture_asserts

bind mce_capture mce_capture_asserts #(.DATA_W(DATA_W)) u_mce_capture_asserts (.*);

// file: tb/mce_sys_model.sv
// Far-side partner: system clock phase, fill-error pulse, command-fail timing.
// Assumes one-cycle request pulses from the bench and a 3:1 clock ratio.
`timescale 1ns/1ns
module mce_sys_model (
  input wire logic core_clk, rst, errReq, failReq, failAck,
  output logic sysCycle, fillErrorIn, fillStrobe, cmdFail, cmdAckIn
);
  logic [1:0] phase, next_phase;
  logic errPulse, next_errPulse, failPend, next_failPend, ackHeld, next_ackHeld;
  always_comb begin
    next_phase = (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    next_errPulse = errReq;
    next_failPend = failReq | (failPend & !sysCycle);
    next_ackHeld = failReq ? failAck : ackHeld;
    if (rst) begin
      {next_phase, next_errPulse, next_failPend, next_ackHeld} = '0;
    end
  end
  always_ff @(posedge core_clk) begin
    {phase, errPulse, failPend, ackHeld} <= {next_phase, next_errPulse, next_failPend, next_ackHeld};
  end
  assign sysCycle = (phase == 2'h2);
  // Error ends the fill in one cycle, beside its ordinary fill word
  assign fillErrorIn = errPulse;
  assign fillStrobe = errPulse;
  // Fail only counts on a system clock cycle
  assign cmdFail = failPend & sysCycle;
  assign cmdAckIn = cmdFail & ackHeld;
endmodule : mce_sys_model

// file: tb/test_machine_check_error_capture.sv
// Self-checking bench for the machine-check error capture block.
// Assumes the system model and the bound checker are compiled with it.
`timescale 1ns/1ns
module test_machine_check_error_capture import mce_pkg::*;;
  logic core_clk = 0, rst = 1, ce = 1, privMode = 0, crdEnable = 1, bcProbe = 0, bcProbeIstream = 0;
  logic bcTagMatch = 0, bcTagParOk = 1, bcCtlParOk = 1, sysCmdValid = 0, sysCmdNop = 0, sysCmdParErr = 0;
  logic bcReadOut = 0, fillV = 0, fillIstream = 0, fillFromBcache = 0, fillCorrErr = 0, sysMcheckIn = 0;
  logic iuTimeout = 0, l2Err = 0, arithExc = 0, ifetchInstr = 0, rdL2Status = 0, rdExtStatus = 0;
  logic wrIcStatus = 0, wrDcStatus = 0, clrArithSummary = 0, wrHwIntClr = 0, crdClrBit = 1, mckClrBit = 1;
  logic errReq = 0, failReq = 0, failAck = 0;
  logic [3:0] clkRatio = 4'h1, dcErr = 4'h0;
  logic [4:0] ipl = 5'h00;
  logic [2:0] bcTagStatus = 3'h0;
  logic [1:0] icParErr = 2'h0;
  logic [15:0] wrData = 16'h0000, fillSyndromeIn = 16'h5a3c;
  logic [31:0] bcProbeResult = 32'h1234abcd;
  logic [39:4] bcProbeAddr = 36'ha1, sysCmdAddr = 36'hb2, fillAddr = 36'hc3, l2ErrAddr = 36'hd4;
  logic [127:0] bcReadOutData = 128'h77, fillData = 128'hf0, fillFlip = 128'h11;
  logic [63:0] excMaskIn = 64'h0;
  logic fillValid, sysCycle, fillErrorIn, fillStrobe, cmdFail, cmdAckIn, bcHit, victimWriteback, cmdAck, cmdNack;
  logic l2FillWe, icFillWe, dcInvalidateAll, mcheckTrap, partialReset, crdInterrupt, mckInterrupt, isrCrd, isrMck;
  logic l2Locked, refillStale;
  logic [127:0] sysDataOut, corrData;
  logic [6:0] extStatus;
  logic [39:4] extAddress, l2Address;
  logic [31:0] tagProbeResult;
  logic [15:0] fillSyndrome, icStatus;
  logic [5:0] dcStatus;
  logic [63:0] excMask;
  int badCount = 0, testsRun = 0;
  // Row: probe tagOk ctlOk match status[2:0] cmd nop par fill ist fromBc | trap hit victim ack nack ext[6:0]
  localparam logic [24:0] ROWS [6] = '{
    {13'b1011_001_000_000, 12'b11000_0000001}, {13'b1100_011_000_000, 12'b10100_0000010},
    {13'b0000_000_100_000, 12'b00010_0000000}, {13'b0000_000_101_000, 12'b10001_0010100},
    {13'b0000_000_000_100, 12'b00000_0100100}, {13'b0000_000_000_111, 12'b00000_0101000}};

  assign fillValid = fillV | fillStrobe;
  always #50 core_clk = ~core_clk;

  mce_sys_model u_mce_sys_model (.*);
  mce_capture u_mce_capture (.*);

  task check(input logic [39:0] got, input logic [39:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check

  // Drops every one-cycle request but clrArithSummary, then lets the answering edge settle
  task go;
    @(posedge core_clk);
    {bcProbe, sysCmdValid, fillV, fillCorrErr, sysMcheckIn, iuTimeout, l2Err, ifetchInstr, rdL2Status, rdExtStatus,
      wrIcStatus, wrDcStatus, wrHwIntClr, bcReadOut, errReq, failReq, icParErr, dcErr, arithExc} <= '0;
    #1;
  endtask : go

  task doReset;
    @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
  endtask : doReset

  task endOfTest;
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : endOfTest

  initial begin
    #3000000;
    badCount++;
    endOfTest;
  end

  initial begin
    int n;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    go;
    check({mcheckTrap, partialReset, isrCrd, isrMck, refillStale, extStatus, icStatus}, 40'h0);
    for (int i = 0; i < 6; i++) begin
      doReset;
      @(posedge core_clk);
      {bcProbe, bcTagParOk, bcCtlParOk, bcTagMatch, bcTagStatus, sysCmdValid, sysCmdNop, sysCmdParErr, fillV,
        fillIstream, fillFromBcache} <= ROWS[i][24:12];
      fillCorrErr <= ROWS[i][14];
      go;
      check({mcheckTrap, bcHit, victimWriteback, cmdAck, cmdNack, extStatus}, ROWS[i][11:0]);
      check(extAddress, ROWS[i][24] ? bcProbeAddr : ROWS[i][15] ? sysCmdAddr : ROWS[i][14] ? fillAddr : '0);
    end
    // Capture group stays locked until its status is read
    doReset;
    @(posedge core_clk); {bcProbe, bcTagParOk} <= 2'b10; go;
    @(posedge core_clk); {sysCmdValid, sysCmdNop, sysCmdParErr} <= 3'b101; go;
    check(extAddress, bcProbeAddr);
    check(extStatus[ES_MULTI], 1'b1);
    @(posedge core_clk); rdExtStatus <= 1; bcProbeResult <= 32'h0; go;
    @(posedge core_clk); {fillV, fillCorrErr, fillIstream} <= 3'b111; go;
    check(extAddress, fillAddr);
    check({fillSyndrome, tagProbeResult}, {16'h5a3c, 32'h1234abcd});
    check({crdInterrupt, icFillWe, dcInvalidateAll}, 3'b111);
    @(posedge core_clk); ipl <= IPL_MCHECK; #1; check(crdInterrupt, 1'b0);
    @(posedge core_clk); {ipl, crdEnable} <= 6'h00; #1; check(crdInterrupt, 1'b0);
    for (int i = 1; i >= 0; i--) begin
      @(posedge core_clk); wrHwIntClr <= 1; crdClrBit <= i[0]; go;
      check(isrCrd, i[0]);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk); privMode <= (i == 0); ipl <= (i == 1) ? IPL_MCHECK : 5'h00; sysMcheckIn <= 1; go;
      check({isrMck, mckInterrupt}, (i == 2) ? 2'b11 : 2'b00);
    end
    @(posedge core_clk); wrHwIntClr <= 1; mckClrBit <= 0; go;
    check(isrMck, 1'b0);
    // Fill error traps but leaves every status alone
    doReset;
    @(posedge core_clk); errReq <= 1; bcReadOut <= 1; go;
    go;
    check({mcheckTrap, partialReset, extStatus, icStatus}, {2'b10, 23'h0});
    check(sysDataOut[39:0], bcReadOutData[39:0]);
    @(posedge core_clk); iuTimeout <= 1; go;
    check({mcheckTrap, partialReset, icStatus[IC_TMR]}, 3'b111);
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk); wrIcStatus <= 1; wrData <= i ? IC_UNLOCK_VAL : 16'h17ff; go;
      check(icStatus[IC_TMR], !i);
    end
    @(posedge core_clk); dcErr <= 4'h1; go;
    @(posedge core_clk); dcErr <= 4'h2; go;
    check(dcStatus, 6'h31);
    @(posedge core_clk); wrDcStatus <= 1; wrData <= {8'h00, DC_UNLOCK_VAL}; go;
    @(posedge core_clk); dcErr <= 4'h4; go;
    check(dcStatus, 6'h14);
    for (int i = 1; i >= 0; i--) begin
      @(posedge core_clk); failReq <= 1; failAck <= i[0]; go;
      n = 0;
      while (cmdFail !== 1'b1 && n < 6) begin
        @(posedge core_clk); #1; n++;
      end
      if (n == 6) begin
        badCount++;
        endOfTest;
      end
      @(posedge core_clk); #1; check(partialReset, !i);
    end
    // Ratio three, then ratio one: good command right after a bad idle command
    for (int i = 0; i < 2; i++) begin
      doReset;
      @(posedge core_clk); clkRatio <= i ? 4'h1 : RATIO_THREE; {sysCmdValid, sysCmdNop, sysCmdParErr} <= 3'b111;
      @(posedge core_clk); {sysCmdNop, sysCmdParErr} <= 2'b00; #1;
      check(mcheckTrap, 1'b1);
      go;
      check({cmdAck, cmdNack}, {i[0], 1'b0});
    end
    @(posedge core_clk); icParErr <= 2'h2; go;
    check(refillStale, 1'b1);
    @(posedge core_clk); ifetchInstr <= 1;
    repeat (31) @(posedge core_clk);
    #1; check(refillStale, 1'b1);
    go;
    check(refillStale, 1'b0);
    @(posedge core_clk); l2Err <= 1; arithExc <= 1; excMaskIn <= 64'h5; go;
    @(posedge core_clk); l2Err <= 1; arithExc <= 1; l2ErrAddr <= 36'hd5; excMaskIn <= 64'h9; go;
    check({l2Locked, l2Address, excMask[2:0]}, {1'b1, 36'hd4, 3'h5});
    @(posedge core_clk); rdL2Status <= 1; clrArithSummary <= 1;
    @(posedge core_clk); clrArithSummary <= 0; l2Err <= 1; arithExc <= 1; go;
    check({l2Locked, l2Address, excMask[2:0]}, {1'b1, 36'hd5, 3'h1});
    endOfTest;
  end
endmodule : test_machine_check_error_capture
